// file: core/srange_pkg.sv
package srange_pkg;
  localparam int RANGE_W = 3;
  localparam logic [RANGE_W-1:0] RANGE_LEAST = 3'h0;
  localparam logic [RANGE_W-1:0] RANGE_MOST = 3'h7;
  localparam int SAMPLE_W = 8;
  localparam logic [SAMPLE_W-1:0] OVER_LEVEL = 8'h78;
  localparam logic [SAMPLE_W-1:0] UNDER_LEVEL = 8'h10;
  localparam int TIMEOUT_W = 24;
  localparam int FREQ_W = 20;
  localparam int ACC_W = 32;
  localparam logic [ACC_W-1:0] FREQ_BASE = 32'h0010_0000;
  localparam int FREQ_SHIFT = 8;
  localparam int JITTER_SHIFT = 7;
  localparam int RAND_W = 8;
  localparam logic [RAND_W-1:0] LFSR_SEED = 8'hA5;
  localparam logic [RAND_W-1:0] LFSR_TAPS = 8'hB8;
  localparam int STEP_W = 6;
  localparam logic [STEP_W-1:0] STEP_LAST = 6'h39;
  localparam logic [ACC_W-1:0] FILT_BASE = 32'h0000_8000;
  localparam logic [2:0] RATIO_NUM = 3'h6;
  localparam logic [2:0] RATIO_DEN = 3'h5;
  localparam int LINES = 3;
  localparam logic [1:0] LINE_NONE = 2'h3;
  localparam logic [1:0] SRC_PROG = 2'h0;
  localparam logic [1:0] SRC_MEAS_A = 2'h1;
  localparam logic [1:0] SRC_MEAS_B = 2'h2;
endpackage

// file: core/autorange_and_sample_clock_ctrl.sv
// Function
// R1 - Check each channel's samples for overload
// R2 - Overload steps range down and notifies
// R3 - Underload timeout steps range up, notifies
// R4 - Processor supplies underload timeout per input
// R5 - Ranging runs continuously, independently per input
// R6 - Fixed range suppresses automatic range changes
// R7 - Range and mode driven as parallel codes
// R8 - Frequency setting 20 bits over 2:1
// R9 - Sample clock on one of three lines
// R10 - Optionally lock to measured input frequency
// R11 - Period jitter at most one percent
// R12 - 256-period average within 1ppm of setting
// R13 - Filter clock 1.2 steps, 4.5 decades
// R14 - Processor tells subsystems which lines used
// R15 - LFSR-perturbed accumulator, zero-mean jitter
// R16 - At extreme range, no change, no notice
`timescale 1ns/1ps
module autorange_channel
  import srange_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid_in,
  input wire logic [TIMEOUT_W-1:0] timeout_in,
  input wire logic fixed_in,
  input wire logic [RANGE_W-1:0] fixed_range_in,
  output logic [RANGE_W-1:0] range_out,
  output logic fixed_mode_out,
  output logic changed_out
);
  logic [TIMEOUT_W-1:0] under_count;
  logic [RANGE_W-1:0] range;
  logic changed;
  logic fixed_mode;
  wire [SAMPLE_W-1:0] mag = sample_in[SAMPLE_W-1] ? SAMPLE_W'(~sample_in + 8'h01) : sample_in;
  wire over = sample_valid_in && (mag >= OVER_LEVEL); // R1
  wire under = mag < UNDER_LEVEL;
  wire timed_out = sample_valid_in && under && (under_count >= timeout_in); // R3 R4
  wire step_down = !fixed_in && over && (range != RANGE_LEAST); // R2 R16
  wire step_up = !fixed_in && !over && timed_out && (range != RANGE_MOST); // R3 R16
  wire [RANGE_W-1:0] next_range = fixed_in ? fixed_range_in : // R6
    step_down ? RANGE_W'(range - 3'h1) : step_up ? RANGE_W'(range + 3'h1) : range;
  wire count_clear = !under || step_up || step_down || fixed_in;
  wire [TIMEOUT_W-1:0] next_under_count = !sample_valid_in ? under_count :
    count_clear ? '0 : (&under_count) ? under_count : TIMEOUT_W'(under_count + 24'h1);

  // The counter saturates so a very long quiet spell cannot wrap and hide the timeout.
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      under_count <= '0;
      range <= RANGE_LEAST;
      changed <= 1'b0;
      fixed_mode <= 1'b0;
    end
    else
    begin
      under_count <= next_under_count; // R5
      range <= next_range;
      changed <= step_up || step_down; // R2 R3
      fixed_mode <= fixed_in;
    end
  end

  assign range_out = range; // R7
  assign fixed_mode_out = fixed_mode; // R7
  assign changed_out = changed;

  overload_step_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R2
    (over && !fixed_in && range != RANGE_LEAST) |=> (changed && range == $past(range) - 3'h1))
    else $error("Overload did not step the range down.");
  extreme_quiet_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R16
    (!fixed_in && over && range == RANGE_LEAST) |=> (!changed && range == RANGE_LEAST))
    else $error("Range changed at the least sensitive end.");
  fixed_hold_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R6
    fixed_in |=> (!changed && range == $past(fixed_range_in)))
    else $error("Fixed range did not hold.");
  underload_step_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R3
    (step_up) |=> (changed && range == $past(range) + 3'h1 && under_count == '0))
    else $error("Underload timeout did not step the range up.");
  early_step_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R3
    (range == RANGE_W'($past(range) + 3'h1) && !$past(fixed_in)) |->
    $past(under_count >= timeout_in))
    else $error("Range rose before the underload timeout.");
  notify_pair_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R5
    (changed && !$past(fixed_in)) |-> (range != $past(range)))
    else $error("Notification without a range change.");
  overload_seen_c: cover property (@(posedge clock_in) disable iff (!nrst_in) step_down);
  underload_seen_c: cover property (@(posedge clock_in) disable iff (!nrst_in) step_up);
endmodule

`timescale 1ns/1ps
module autorange_and_sample_clock_ctrl
  import srange_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [SAMPLE_W-1:0] sample_a_in,
  input wire logic [SAMPLE_W-1:0] sample_b_in,
  input wire logic sample_valid_in,
  input wire logic [TIMEOUT_W-1:0] timeout_a_in,
  input wire logic [TIMEOUT_W-1:0] timeout_b_in,
  input wire logic fixed_a_in,
  input wire logic fixed_b_in,
  input wire logic [RANGE_W-1:0] fixed_range_a_in,
  input wire logic [RANGE_W-1:0] fixed_range_b_in,
  input wire logic [FREQ_W-1:0] freq_set_in,
  input wire logic [FREQ_W-1:0] meas_freq_a_in,
  input wire logic [FREQ_W-1:0] meas_freq_b_in,
  input wire logic [1:0] freq_source_in,
  input wire logic [1:0] sclk_line_in,
  input wire logic [STEP_W-1:0] filt_step_in,
  input wire logic [1:0] fclk_line_in,
  output logic [RANGE_W-1:0] range_a_out,
  output logic [RANGE_W-1:0] range_b_out,
  output logic fixed_mode_a_out,
  output logic fixed_mode_b_out,
  output logic range_changed_a_out,
  output logic range_changed_b_out,
  output logic [LINES-1:0] sclk_line_out,
  output logic [LINES-1:0] sclk_line_oe_out,
  output logic [LINES-1:0] fclk_line_out,
  output logic [LINES-1:0] fclk_line_oe_out
);
  autorange_channel chan_a (
    .clock_in(clock_in), .nrst_in(nrst_in), .sample_in(sample_a_in),
    .sample_valid_in(sample_valid_in), .timeout_in(timeout_a_in), .fixed_in(fixed_a_in),
    .fixed_range_in(fixed_range_a_in), .range_out(range_a_out),
    .fixed_mode_out(fixed_mode_a_out), .changed_out(range_changed_a_out)
  );
  autorange_channel chan_b (
    .clock_in(clock_in), .nrst_in(nrst_in), .sample_in(sample_b_in),
    .sample_valid_in(sample_valid_in), .timeout_in(timeout_b_in), .fixed_in(fixed_b_in),
    .fixed_range_in(fixed_range_b_in), .range_out(range_b_out),
    .fixed_mode_out(fixed_mode_b_out), .changed_out(range_changed_b_out)
  );

  // Sample clock: the nominal increment spans base to twice base over the 20-bit code.
  logic [ACC_W-1:0] sacc;
  logic [RAND_W-1:0] lfsr;
  logic [ACC_W-1:0] pert;
  logic pert_neg;
  logic sclk;
  wire [FREQ_W-1:0] freq_code = (freq_source_in == SRC_MEAS_A) ? meas_freq_a_in : // R10
    (freq_source_in == SRC_MEAS_B) ? meas_freq_b_in : freq_set_in;
  wire [ACC_W-1:0] nominal = FREQ_BASE + (ACC_W'(freq_code)); // R8
  wire [ACC_W-1:0] nominal_inc = ACC_W'(nominal << FREQ_SHIFT);
  wire [ACC_W+RAND_W-1:0] pert_full = (nominal_inc >> JITTER_SHIFT) * lfsr;
  wire [ACC_W-1:0] next_pert = ACC_W'(pert_full >> RAND_W); // R11
  // A frequency change acts at once, so an offset drawn for a faster clock is clipped
  // to the new bound rather than waiting up to two periods for a fresh draw.
  wire [ACC_W-1:0] jitter_max = nominal_inc >> JITTER_SHIFT;
  wire [ACC_W-1:0] pert_used = (pert > jitter_max) ? jitter_max : pert; // R11
  wire [ACC_W-1:0] sinc = pert_neg ? nominal_inc - pert_used : nominal_inc + pert_used; // R15
  wire [ACC_W-1:0] next_sacc = sacc + sinc;
  wire period_start = next_sacc[ACC_W-1] && !sacc[ACC_W-1];
  wire [RAND_W-1:0] next_lfsr = lfsr[0] ? (lfsr >> 1) ^ LFSR_TAPS : lfsr >> 1;

  // Each random offset is applied once up and once down on successive periods, so the
  // long-run mean equals the set value; the price is that jitter is correlated in pairs.
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sacc <= '0;
      lfsr <= LFSR_SEED;
      pert <= '0;
      pert_neg <= 1'b0;
      sclk <= 1'b0;
    end
    else
    begin
      sacc <= next_sacc;
      sclk <= next_sacc[ACC_W-1];
      if (period_start)
      begin
        pert_neg <= !pert_neg; // R12 R15
        if (pert_neg)
        begin
          lfsr <= next_lfsr;
          pert <= next_pert;
        end
      end
    end
  end

  // Filter clock: the increment is rebuilt by repeated 6/5 scaling whenever the step moves.
  logic [ACC_W-1:0] facc;
  logic [ACC_W-1:0] finc;
  logic [STEP_W-1:0] built_step;
  logic [STEP_W-1:0] want_step;
  logic fclk;
  wire [STEP_W-1:0] step_clamped = (filt_step_in > STEP_LAST) ? STEP_LAST : filt_step_in;
  wire rebuild = step_clamped != want_step;
  wire [ACC_W+2:0] finc_scaled = (ACC_W+3)'(finc * RATIO_NUM) / RATIO_DEN;
  wire building = built_step != want_step;

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      facc <= '0;
      finc <= FILT_BASE;
      built_step <= '0;
      want_step <= '0;
      fclk <= 1'b0;
    end
    else
    begin
      facc <= facc + finc;
      fclk <= facc[ACC_W-1];
      want_step <= step_clamped;
      if (rebuild)
      begin
        finc <= FILT_BASE;
        built_step <= '0;
      end
      else if (building)
      begin
        finc <= ACC_W'(finc_scaled); // R13
        built_step <= STEP_W'(built_step + 6'h01);
      end
    end
  end

  // Only the chosen line is driven; the code for no line leaves all three released.
  genvar g;
  generate
    for (g = 0; g < LINES; g++)
    begin : line_drive
      assign sclk_line_oe_out[g] = (sclk_line_in == 2'(g)); // R9
      assign sclk_line_out[g] = sclk_line_oe_out[g] && sclk;
      assign fclk_line_oe_out[g] = (fclk_line_in == 2'(g)); // R13
      assign fclk_line_out[g] = fclk_line_oe_out[g] && fclk;
    end
  endgenerate

  jitter_bound_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R11
    (sinc >= nominal_inc - jitter_max) && (sinc <= nominal_inc + jitter_max))
    else $error("Jitter offset exceeds one percent of the increment.");
  jitter_pair_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R12
    (period_start && !pert_neg) |=> $stable(pert) && pert_neg)
    else $error("Jitter offset changed before its opposite half.");
  link_source_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R10
    (freq_source_in == SRC_MEAS_A) |-> (nominal == FREQ_BASE + ACC_W'(meas_freq_a_in)))
    else $error("Sample clock not locked to input A.");
  line_single_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R9
    $onehot0(sclk_line_oe_out) && $onehot0(fclk_line_oe_out))
    else $error("More than one clock line driven.");
  filter_build_a: assert property (@(posedge clock_in) disable iff (!nrst_in) // R13
    (rebuild) |=> (finc == FILT_BASE && built_step == '0))
    else $error("Filter increment not restarted on step change.");
  sclk_toggle_c: cover property (@(posedge clock_in) disable iff (!nrst_in) period_start);
  filter_done_c: cover property (@(posedge clock_in) disable iff (!nrst_in)
    $fell(building) && want_step == STEP_LAST);
endmodule

// file: tb/cpu_link_model.sv
`timescale 1ns/1ps
module cpu_link_model
  import srange_pkg::*;
#(
  parameter logic [TIMEOUT_W-1:0] TIMEOUT_A = 24'h000003,
  parameter logic [TIMEOUT_W-1:0] TIMEOUT_B = 24'h000005
)
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic changed_a_in,
  input wire logic changed_b_in,
  output logic [TIMEOUT_W-1:0] timeout_a_out,
  output logic [TIMEOUT_W-1:0] timeout_b_out,
  output logic [7:0] notes_a_out,
  output logic [7:0] notes_b_out
);
  // Distinct timeouts per input, so a swapped pair shows at the ports.
  assign timeout_a_out = TIMEOUT_A;
  assign timeout_b_out = TIMEOUT_B;
  // Notices are counted so that a lost or doubled pulse can be told apart.
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      notes_a_out <= 8'h00;
      notes_b_out <= 8'h00;
    end
    else
    begin
      notes_a_out <= notes_a_out + {7'h00, changed_a_in};
      notes_b_out <= notes_b_out + {7'h00, changed_b_in};
    end
  end
endmodule

// file: tb/tb_autorange_and_sample_clock_ctrl.sv
`timescale 1ns/1ps
module tb_autorange_and_sample_clock_ctrl
  import srange_pkg::*;
;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [SAMPLE_W-1:0] sample_a = 8'h00;
  logic [SAMPLE_W-1:0] sample_b = 8'h00;
  logic sample_valid = 1'b0;
  logic fixed_a = 1'b0;
  logic fixed_b = 1'b0;
  logic [RANGE_W-1:0] fixed_range_a = 3'h0;
  logic [RANGE_W-1:0] fixed_range_b = 3'h0;
  logic [FREQ_W-1:0] freq_set = 20'h00000;
  logic [FREQ_W-1:0] meas_a = 20'hFFFFF;
  logic [FREQ_W-1:0] meas_b = 20'h80000;
  logic [1:0] freq_source = 2'h0;
  logic [1:0] sclk_line = 2'h0;
  logic [STEP_W-1:0] filt_step = 6'h00;
  logic [1:0] fclk_line = 2'h0;
  logic [TIMEOUT_W-1:0] timeout_a;
  logic [TIMEOUT_W-1:0] timeout_b;
  logic [RANGE_W-1:0] range_a;
  logic [RANGE_W-1:0] range_b;
  logic mode_a;
  logic mode_b;
  logic chg_a;
  logic chg_b;
  logic [LINES-1:0] sclk_l;
  logic [LINES-1:0] sclk_oe;
  logic [LINES-1:0] fclk_l;
  logic [LINES-1:0] fclk_oe;
  logic [7:0] notes_a;
  logic [7:0] notes_b;
  wire sclk = |(sclk_l & sclk_oe);
  wire fclk = |(fclk_l & fclk_oe);
  int err_count = 0;
  int n_compared = 0;

  always #4 clock_in = ~clock_in;

  cpu_link_model cpu_link_model_i (.clock_in(clock_in), .nrst_in(nrst_in),
    .changed_a_in(chg_a), .changed_b_in(chg_b), .timeout_a_out(timeout_a),
    .timeout_b_out(timeout_b), .notes_a_out(notes_a), .notes_b_out(notes_b));

  autorange_and_sample_clock_ctrl autorange_and_sample_clock_ctrl_i (
    .clock_in(clock_in), .nrst_in(nrst_in), .sample_a_in(sample_a), .sample_b_in(sample_b),
    .sample_valid_in(sample_valid), .timeout_a_in(timeout_a), .timeout_b_in(timeout_b),
    .fixed_a_in(fixed_a), .fixed_b_in(fixed_b), .fixed_range_a_in(fixed_range_a),
    .fixed_range_b_in(fixed_range_b), .freq_set_in(freq_set), .meas_freq_a_in(meas_a),
    .meas_freq_b_in(meas_b), .freq_source_in(freq_source), .sclk_line_in(sclk_line),
    .filt_step_in(filt_step), .fclk_line_in(fclk_line), .range_a_out(range_a),
    .range_b_out(range_b), .fixed_mode_a_out(mode_a), .fixed_mode_b_out(mode_b),
    .range_changed_a_out(chg_a), .range_changed_b_out(chg_b), .sclk_line_out(sclk_l),
    .sclk_line_oe_out(sclk_oe), .fclk_line_out(fclk_l), .fclk_line_oe_out(fclk_oe));

  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Clock edge counts carry two edges of slack either side of the expected count.
  task automatic near(input string what, input int exp, input int got);
    n_compared++;
    if (got < exp - 2 || got > exp + 2)
    begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  function automatic int edges(input longint inc, input int cyc);
    return int'((inc * longint'(cyc)) >> 32);
  endfunction

  task automatic samp(input logic [7:0] a, input logic [7:0] b, input int n);
    step(1);
    sample_a = a;
    sample_b = b;
    sample_valid = 1'b1;
    step(n);
    sample_valid = 1'b0;
  endtask

  task automatic count(input bit filt, input int cyc, output int n);
    logic p;
    n = 0;
    p = filt ? fclk : sclk;
    repeat (cyc)
    begin
      step(1);
      if ((filt ? fclk : sclk) === 1'b1 && p === 1'b0)
        n++;
      p = filt ? fclk : sclk;
    end
  endtask

  task automatic t_autorange();
    samp(8'h05, 8'h00, 3);
    chk("range_a quiet", 3'h0, range_a);
    samp(8'h05, 8'h00, 1);
    chk("range_a up", 3'h1, range_a);
    chk("changed_a up", 1'b1, chg_a);
    chk("range_b early", 3'h0, range_b);
    samp(8'h40, 8'h00, 2);
    chk("range_b up", 3'h1, range_b);
    chk("changed_b up", 1'b1, chg_b);
    chk("range_a kept", 3'h1, range_a);
    samp(8'h88, 8'h40, 1);
    chk("range_a down", 3'h0, range_a);
    chk("changed_a down", 1'b1, chg_a);
    samp(8'h88, 8'h40, 1);
    chk("changed_a least", 1'b0, chg_a);
    chk("notices_a", 8'h02, notes_a);
    chk("notices_b", 8'h01, notes_b);
  endtask

  task automatic t_fixed();
    fixed_range_a = 3'h5;
    fixed_range_b = 3'h2;
    fixed_a = 1'b1;
    fixed_b = 1'b1;
    step(1);
    chk("fixed range", 3'h5, range_a);
    chk("fixed mode", 1'b1, mode_a);
    chk("fixed range_b", 3'h2, range_b);
    chk("fixed mode_b", 1'b1, mode_b);
    samp(8'h88, 8'h40, 2);
    chk("fixed held", 3'h5, range_a);
    chk("fixed no pulse", 1'b0, chg_a);
    chk("fixed no pulse b", 1'b0, chg_b);
    fixed_a = 1'b0;
    fixed_b = 1'b0;
    step(1);
    chk("auto mode", 1'b0, mode_a);
    chk("auto mode_b", 1'b0, mode_b);
  endtask

  task automatic t_lines();
    for (int l = 0; l < 4; l++)
    begin
      sclk_line = l[1:0];
      fclk_line = l[1:0];
      step(1);
      chk("sclk oe", (l == 3) ? 3'h0 : 3'h1 << l, sclk_oe);
      chk("fclk oe", (l == 3) ? 3'h0 : 3'h1 << l, fclk_oe);
      chk("sclk idle lines", 3'h0, sclk_l & ~sclk_oe);
      chk("fclk idle lines", 3'h0, fclk_l & ~fclk_oe);
    end
    sclk_line = 2'h1;
    fclk_line = 2'h2;
  endtask

  task automatic t_freq();
    int n;
    int e;
    for (int i = 0; i < 5; i++)
    begin
      freq_set = (i == 1) ? 20'hFFFFF : (i == 4) ? 20'h40000 : 20'h00000;
      freq_source = (i < 2) ? 2'h0 : 2'(i - 1);
      e = (i == 1 || i == 2) ? 'hFFFFF : (i == 3) ? 'h80000 : (i == 4) ? 'h40000 : 0;
      step(16);
      count(1'b0, 4096, n);
      near("sclk edges", edges((longint'(FREQ_BASE) + e) << FREQ_SHIFT, 4096), n);
    end
  endtask

  task automatic t_filt();
    int steps [3] = '{40, 57, 63};
    longint inc;
    int n;
    for (int i = 0; i < 3; i++)
    begin
      filt_step = 6'(steps[i]);
      inc = 32'h0000_8000;
      repeat ((steps[i] > 57) ? 57 : steps[i]) inc = inc * 6 / 5;
      step(80);
      count(1'b1, 4096, n);
      near("fclk edges", edges(inc, 4096), n);
    end
  endtask

  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    step(12);
    nrst_in = 1'b1;
    step(2);
    t_autorange();
    t_fixed();
    t_lines();
    t_freq();
    t_filt();
    end_of_test();
  end
endmodule
